/* core/nvm_seq_pkg.sv */
package nvm_seq_pkg;

	// register byte offsets inside the register page
	localparam logic [7:0]  DIV_OFS   = 8'h00; // clock divider
	localparam logic [7:0]  CFG_OFS   = 8'h04; // configuration
	localparam logic [7:0]  OPT_OFS   = 8'h08; // option copy
	localparam logic [7:0]  PROT_OFS  = 8'h0c; // protection copy
	localparam logic [7:0]  CMD_OFS   = 8'h10; // command buffer
	localparam logic [7:0]  STAT_OFS  = 8'h14; // status
	// upper address bits of the two windows
	localparam logic [23:0] REG_PAGE  = 24'h00_0000;
	localparam logic [15:0] ARR_PAGE  = 16'h0001;

	// field positions
	localparam int DIV_LOADED_BIT = 7;  // read-only: divider written
	localparam int CFG_PAGE_BIT   = 0;  // eeprom page select
	localparam int OPT_MODE_BIT   = 0;  // eeprom sector mode
	localparam int STAT_CBEF_BIT  = 7;  // command buffer empty
	localparam int STAT_CCF_BIT   = 6;  // command complete
	localparam int STAT_ERR_BIT   = 4;  // access error
	localparam int EE_HALF_LSB    = 2;  // 4-byte half inside a sector
	localparam int EE_SECT_LSB    = 3;  // 8-byte sector boundary

	// reset values
	localparam logic [6:0]  DIV_RST   = 7'h00;
	localparam logic [7:0]  CMD_RST   = 8'h00;

	// command codes
	localparam logic [7:0] CMD_BLANK_CHECK  = 8'h05;
	localparam logic [7:0] CMD_BYTE_PROG    = 8'h20;
	localparam logic [7:0] CMD_BURST_PROG   = 8'h25;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
	localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;
	localparam logic [7:0] CMD_ERASE_ABORT  = 8'h47;

	// operation lengths in timing-clock cycles
	localparam int BYTE_TICKS   = 9;
	localparam int BURST_TICKS  = 4;
	localparam int SECTOR_TICKS = 4000;
	localparam int MASS_TICKS   = 20000;
	localparam int ABORT_TICKS  = 4;
	localparam int BLANK_TICKS  = 9;

	// command sequence states
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_ADDR = 3'b010,
		SEQ_CMD  = 3'b100
	} seq_t;

	// array operation states
	typedef enum logic [2:0] {
		OP_IDLE = 3'b001,
		OP_RUN  = 3'b010,
		OP_HOLD = 3'b100
	} op_t;

	// bus access target
	typedef enum logic [2:0] {
		K_NONE, K_ARRAY, K_DIV, K_CFG, K_OPT, K_PROT, K_CMD, K_STAT
	} kind_t;

	// request handed to the arrays
	typedef struct packed {
		logic [7:0]  code;   // command code
		logic        eeprom; // 1 eeprom array, 0 flash array
		logic [16:0] addr;   // physical byte or sector base
		logic [7:0]  data;   // program data, zero for erase
	} array_req_t;

	// whole sequencer state
	typedef struct packed {
		seq_t        seq;
		op_t         op;
		logic [6:0]  div;
		logic        div_loaded;
		logic        page_sel;
		logic        sector_mode;
		logic [7:0]  protect;
		logic        opt_loaded;
		logic [7:0]  cmd;
		logic [15:0] addr;
		logic [7:0]  data;
		logic        cbef;
		logic        ccf;
		logic        accerr;
		logic [6:0]  prediv;
		logic [15:0] ticks;
		logic        hv;
		logic        burst_run;
		array_req_t  req;
		logic        req_start;
	} seq_state_t;

endpackage : nvm_seq_pkg

/* core/nvm_command_sequencer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - timing clock is divided bus clock
// - fixed cycle counts per operation
// - array write captures address and data
// - erase and blank check ignore data
// - sector erase takes any sector address
// - flash and eeprom erase independently
// - command write latches code into buffer
// - only six command codes are valid
// - writing one launches buffered command
// - writing zero aborts, sets access error
// - broken sequence refused, memory untouched
// - complete flag set when operation ends
// - burst keeps high voltage between bytes
// - pump on at start, off at end
// - page select picks visible eeprom half
// - split mode: 4-byte halves share addresses
// - split mode erase clears all eight bytes
// - sector mode: whole sectors per page
// - option locations copied after reset
// - divider bit7 status, low bits write-once
module nvm_command_sequencer
	import nvm_seq_pkg::*;
#(
	parameter logic [15:0] EE_TOP       = 16'h0400, // eeprom window size
	parameter int          BYTE_CYC     = BYTE_TICKS,
	parameter int          BURST_CYC    = BURST_TICKS,
	parameter int          SECTOR_CYC   = SECTOR_TICKS,
	parameter int          MASS_CYC     = MASS_TICKS,
	parameter int          ABORT_CYC    = ABORT_TICKS,
	parameter int          BLANK_CYC    = BLANK_TICKS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// nonvolatile option locations
	input  wire logic [7:0]  nv_option_in,
	input  wire logic [7:0]  nv_protect_in,
	// array side
	output array_req_t       array_req,
	output logic             array_req_start,
	output logic             hv_pump_enable
);

	// refuse erase counts over 65535 and zero counts for the other operations
	if (MASS_CYC > 65535 || SECTOR_CYC > 65535 || BYTE_CYC < 1 ||
	    BURST_CYC < 1 || ABORT_CYC < 1 || BLANK_CYC < 1) begin : g_chk
		$error("nvm_command_sequencer: operation count out of range");
	end

	seq_state_t s_q;       // registered state
	seq_state_t s_d;       // next state
	kind_t      acc_kind;  // decoded target of current access
	logic       bus_wr;    // write in access phase
	logic       stat_wr;   // write to status
	logic       launch_req;// one written to buffer empty flag
	logic       abort_ok;  // abort hits a running sector erase
	logic       launch_ok; // launch accepted this cycle
	logic       tick;      // one timing-clock period elapsed
	logic       set_err;   // access error event
	logic       clr_err;   // software clears the error flag

	// map a bus address onto a register or the array window
	function automatic kind_t decode_addr(input logic [31:0] a);
		if (a[31:16] == ARR_PAGE) begin
			decode_addr = K_ARRAY;
		end else if (a[31:8] != REG_PAGE) begin
			decode_addr = K_NONE;
		end else if (a[7:0] == DIV_OFS) begin
			decode_addr = K_DIV;
		end else if (a[7:0] == CFG_OFS) begin
			decode_addr = K_CFG;
		end else if (a[7:0] == OPT_OFS) begin
			decode_addr = K_OPT;
		end else if (a[7:0] == PROT_OFS) begin
			decode_addr = K_PROT;
		end else if (a[7:0] == CMD_OFS) begin
			decode_addr = K_CMD;
		end else if (a[7:0] == STAT_OFS) begin
			decode_addr = K_STAT;
		end else begin
			decode_addr = K_NONE;
		end
	endfunction : decode_addr

	// true for the six accepted codes
	function automatic logic valid_code(input logic [7:0] c);
		valid_code = (c == CMD_BLANK_CHECK) || (c == CMD_BYTE_PROG) ||
		             (c == CMD_BURST_PROG) || (c == CMD_SECTOR_ERASE) ||
		             (c == CMD_MASS_ERASE) || (c == CMD_ERASE_ABORT);
	endfunction : valid_code

	// timing-clock cycles an operation lasts
	function automatic logic [15:0] duration(input logic [7:0] c,
	                                         input logic       held);
		if (c == CMD_BURST_PROG && held) begin
			duration = 16'(BURST_CYC);
		end else if (c == CMD_BYTE_PROG || c == CMD_BURST_PROG) begin
			duration = 16'(BYTE_CYC);
		end else if (c == CMD_SECTOR_ERASE) begin
			duration = 16'(SECTOR_CYC);
		end else if (c == CMD_MASS_ERASE) begin
			duration = 16'(MASS_CYC);
		end else if (c == CMD_ERASE_ABORT) begin
			duration = 16'(ABORT_CYC);
		end else begin
			duration = 16'(BLANK_CYC);
		end
	endfunction : duration

	// build the physical request from the captured write
	function automatic array_req_t build_req(input logic [7:0]  c,
	                                         input logic [15:0] a,
	                                         input logic [7:0]  d,
	                                         input logic        pg,
	                                         input logic        md);
		array_req_t r;
		r.code   = c;
		r.eeprom = (a < EE_TOP);
		if (!r.eeprom) begin
			r.addr = {1'b0, a};
		end else if (!md) begin
			// halves share bus addresses, page picks one
			r.addr = {a[15:EE_HALF_LSB], pg, a[EE_HALF_LSB-1:0]};
		end else begin
			// whole sectors live in one page
			r.addr = {pg, a};
		end
		if (c == CMD_SECTOR_ERASE) begin
			// any byte in the sector names the sector
			r.addr[EE_SECT_LSB-1:0] = 3'h0;
		end else if (c == CMD_MASS_ERASE || c == CMD_BLANK_CHECK) begin
			r.addr = 17'h0_0000;
		end
		if (c == CMD_BYTE_PROG || c == CMD_BURST_PROG) begin
			r.data = d;
		end else begin
			r.data = 8'h00;
		end
		build_req = r;
	endfunction : build_req

	// access decode and launch qualification
	assign acc_kind   = decode_addr(paddr);
	assign bus_wr     = psel & penable & pwrite;
	assign stat_wr    = bus_wr & (acc_kind == K_STAT);
	assign launch_req = stat_wr & pwdata[STAT_CBEF_BIT] &
	                    (s_q.seq == SEQ_CMD);
	assign abort_ok   = (s_q.op == OP_RUN) &
	                    (s_q.req.code == CMD_SECTOR_ERASE) &
	                    (s_q.cmd == CMD_ERASE_ABORT);
	// launch needs divider loaded and no pending error
	assign launch_ok  = launch_req & s_q.div_loaded & ~s_q.accerr &
	                    ((s_q.op != OP_RUN) | abort_ok);
	assign tick       = (s_q.op == OP_RUN) & (s_q.prediv == s_q.div);

	// next-state logic
	always_comb begin
		s_d         = s_q;
		s_d.req_start = 1'b0;
		set_err     = 1'b0;
		clr_err     = 1'b0;
		// copy option locations once after reset release
		if (!s_q.opt_loaded) begin
			s_d.opt_loaded  = 1'b1;
			s_d.sector_mode = nv_option_in[OPT_MODE_BIT];
			s_d.protect     = nv_protect_in;
		end
		// divided timing clock and operation countdown
		if (s_q.op == OP_RUN) begin
			s_d.prediv = tick ? 7'h00 : s_q.prediv + 7'h01;
			if (tick) begin
				if (s_q.ticks == 16'h0001) begin
					s_d.ticks = 16'h0000;
					s_d.ccf   = 1'b1;
					if (s_q.burst_run) begin
						s_d.op = OP_HOLD;
					end else begin
						s_d.op = OP_IDLE;
						s_d.hv = 1'b0;
					end
				end else begin
					s_d.ticks = s_q.ticks - 16'h0001;
				end
			end
		end
		// buffer free again one cycle after acceptance
		if (!s_q.cbef && s_q.seq == SEQ_IDLE) begin
			s_d.cbef = 1'b1;
		end
		// register and array writes
		if (bus_wr) begin
			case (acc_kind)
				K_ARRAY: begin
					if (s_q.seq == SEQ_IDLE && !s_q.accerr) begin
						s_d.addr = paddr[15:0];
						s_d.data = pwdata[7:0];
						s_d.seq  = SEQ_ADDR;
					end else begin
						set_err = 1'b1;
					end
				end
				K_DIV: begin
					if (!s_q.div_loaded) begin
						s_d.div        = pwdata[6:0];
						s_d.div_loaded = 1'b1;
					end
				end
				K_CFG: begin
					s_d.page_sel = pwdata[CFG_PAGE_BIT];
				end
				K_CMD: begin
					if (s_q.seq == SEQ_ADDR && valid_code(pwdata[7:0])) begin
						s_d.cmd = pwdata[7:0];
						s_d.seq = SEQ_CMD;
					end else begin
						set_err = 1'b1;
					end
				end
				K_STAT: begin
					clr_err = pwdata[STAT_ERR_BIT];
					if (!pwdata[STAT_CBEF_BIT] && s_q.seq != SEQ_IDLE) begin
						set_err = 1'b1;
					end else if (launch_req && !launch_ok) begin
						set_err = 1'b1;
					end
				end
				default: begin
					// option copies and unmapped: no effect
				end
			endcase
		end
		// accepted launch starts or retimes an operation
		if (launch_ok) begin
			s_d.cbef      = 1'b0;
			s_d.ccf       = 1'b0;
			s_d.seq       = SEQ_IDLE;
			s_d.op        = OP_RUN;
			s_d.hv        = 1'b1;
			s_d.prediv    = 7'h00;
			s_d.ticks     = duration(s_q.cmd, s_q.op == OP_HOLD);
			s_d.burst_run = (s_q.cmd == CMD_BURST_PROG);
			s_d.req       = build_req(s_q.cmd, s_q.addr, s_q.data,
			                          s_q.page_sel, s_q.sector_mode);
			s_d.req_start = 1'b1;
		end
		// an error drops the partial sequence and any held voltage
		if (set_err) begin
			s_d.seq = SEQ_IDLE;
			if (s_q.op == OP_HOLD) begin
				s_d.op = OP_IDLE;
				s_d.hv = 1'b0;
			end
		end
		// sticky error, the set wins over a clear
		s_d.accerr = set_err | (s_q.accerr & ~clr_err);
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q             <= '0;
			s_q.seq         <= SEQ_IDLE;
			s_q.op          <= OP_IDLE;
			s_q.div         <= DIV_RST;
			s_q.cmd         <= CMD_RST;
			s_q.cbef        <= 1'b1;
			s_q.ccf         <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// read mux, registers sit in the low byte
	always_comb begin
		prdata = 32'h0000_0000;
		if (acc_kind == K_DIV) begin
			prdata[7:0] = {s_q.div_loaded, s_q.div};
		end else if (acc_kind == K_CFG) begin
			prdata[CFG_PAGE_BIT] = s_q.page_sel;
		end else if (acc_kind == K_OPT) begin
			prdata[OPT_MODE_BIT] = s_q.sector_mode;
		end else if (acc_kind == K_PROT) begin
			prdata[7:0] = s_q.protect;
		end else if (acc_kind == K_CMD) begin
			prdata[7:0] = s_q.cmd;
		end else if (acc_kind == K_STAT) begin
			prdata[STAT_CBEF_BIT] = s_q.cbef;
			prdata[STAT_CCF_BIT]  = s_q.ccf;
			prdata[STAT_ERR_BIT]  = s_q.accerr;
		end
	end

	// zero-wait slave, error only on unmapped addresses
	assign pready          = 1'b1;
	assign pslverr         = psel & penable & (acc_kind == K_NONE);
	assign array_req       = s_q.req;
	assign array_req_start = s_q.req_start;
	assign hv_pump_enable  = s_q.hv;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_launch_rearm: assert property (
		launch_ok |=> !s_q.cbef && s_q.req_start ##1 s_q.cbef)
		else $error("buffer empty flag not cleared then rearmed");

	a_zero_abort: assert property (
		stat_wr && !pwdata[STAT_CBEF_BIT] && s_q.seq != SEQ_IDLE
		|=> s_q.accerr && s_q.seq == SEQ_IDLE)
		else $error("abort by zero did not flag access error");

	a_bad_code: assert property (
		bus_wr && acc_kind == K_CMD && !valid_code(pwdata[7:0])
		|=> s_q.accerr && s_q.seq != SEQ_CMD)
		else $error("invalid command code accepted");

	a_array_refused: assert property (
		bus_wr && acc_kind == K_ARRAY && s_q.seq != SEQ_IDLE
		|=> s_q.accerr && !s_q.req_start)
		else $error("out of order array write accepted");

	a_byte_timing: assert property (
		launch_ok && s_q.cmd == CMD_BYTE_PROG && s_q.div == 7'h00
		&& s_q.op == OP_IDLE
		|=> !s_q.ccf ##8 !s_q.ccf ##1 (s_q.ccf && !s_q.hv))
		else $error("byte program did not take nine ticks");

	a_pump_on_run: assert property (
		s_q.op == OP_RUN |-> s_q.hv)
		else $error("pump off while operation runs");

	a_burst_hold: assert property (
		s_q.op == OP_RUN && s_q.burst_run && tick && s_q.ticks == 16'h0001
		|=> s_q.hv && s_q.op == OP_HOLD && s_q.ccf)
		else $error("high voltage dropped between burst bytes");

	a_div_once: assert property (
		s_q.div_loaded |=> $stable(s_q.div) && s_q.div_loaded)
		else $error("divider changed after first write");

	a_erase_align: assert property (
		s_q.req_start && s_q.req.code == CMD_SECTOR_ERASE
		|-> s_q.req.addr[EE_SECT_LSB-1:0] == 3'h0)
		else $error("sector erase base not aligned");

	a_err_sticky: assert property (
		s_q.accerr && !(stat_wr && pwdata[STAT_ERR_BIT])
		|=> s_q.accerr)
		else $error("access error cleared without software write");

	a_option_copy: assert property (
		$rose(s_q.opt_loaded)
		|-> s_q.sector_mode == $past(nv_option_in[OPT_MODE_BIT]))
		else $error("option location not copied");

endmodule : nvm_command_sequencer

/* test/nvm_array_model.sv */
`timescale 1ns/1ps
module nvm_array_model
	import nvm_seq_pkg::*;
(
	// bus clock
	input  wire logic       pclk,
	// requests from the sequencer
	input  wire array_req_t array_req,
	input  wire logic       array_req_start,
	input  wire logic       hv_pump_enable
);
	logic [7:0]  mem [logic [17:0]]; // programmed cells; absent means erased
	logic [17:0] q [$];              // cells picked for a mass erase
	int          pump_faults = 0;    // launches seen with the pump still off
	int          reprog_faults = 0;  // programs of a cell not erased first

	// read a cell; an erased cell reads all ones
	function automatic logic [7:0] rd(input logic ee, input logic [16:0] a);
		return mem.exists({ee, a}) ? mem[{ee, a}] : 8'hff;
	endfunction : rd

	// carry out each launched operation on the cells
	always @(posedge pclk) begin
		if (array_req_start === 1'b1) begin
			if (hv_pump_enable !== 1'b1)
				pump_faults++;
			case (array_req.code)
				// program puts the captured byte in place
				CMD_BYTE_PROG, CMD_BURST_PROG: begin
					// software must erase before it programs a cell again
					if (mem.exists({array_req.eeprom, array_req.addr}))
						reprog_faults++;
					mem[{array_req.eeprom, array_req.addr}] = array_req.data;
				end
				// sector erase clears all eight cells of the sector
				CMD_SECTOR_ERASE: begin
					for (int i = 0; i < 8; i++)
						mem.delete({array_req.eeprom, array_req.addr[16:3],
							3'(i)});
				end
				// mass erase clears only the addressed array
				CMD_MASS_ERASE: begin
					q = {};
					foreach (mem[k])
						if (k[17] == array_req.eeprom)
							q.push_back(k);
					foreach (q[j])
						mem.delete(q[j]);
				end
				// blank check and abort leave the cells alone
				default: begin
				end
			endcase
		end
	end
endmodule : nvm_array_model

/* test/nvm_command_sequencer_bench.sv */
`timescale 1ns/1ps
module nvm_command_sequencer_bench
	import nvm_seq_pkg::*;
;
	// bus side
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// option locations and array side
	logic [7:0]  nv_option_in;
	logic [7:0]  nv_protect_in;
	array_req_t  array_req;
	logic        array_req_start;
	logic        hv_pump_enable;
	// bookkeeping
	int          mismatches = 0;
	int          cmp_count = 0;
	logic [31:0] rd;       // last read data
	logic        err;      // last slave error
	array_req_t  req_seen; // request caught at the launch pulse
	logic        started;  // a launch pulse was seen
	int          dur;      // pump-on cycles since the launch pulse
	int          span;     // cycles waited for the pump to drop
	int          per = 2;  // bus cycles per timing tick, divider plus one
	localparam logic [31:0] ARR = {ARR_PAGE, 16'h0000}; // array window
	localparam logic [31:0] ST = {REG_PAGE, STAT_OFS};  // status address

	// short counts keep the erase runs brief
	nvm_command_sequencer #(.SECTOR_CYC(30), .MASS_CYC(60)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .nv_option_in(nv_option_in),
		.nv_protect_in(nv_protect_in), .array_req(array_req),
		.array_req_start(array_req_start), .hv_pump_enable(hv_pump_enable));
	nvm_array_model mem_model (
		.pclk(pclk), .array_req(array_req),
		.array_req_start(array_req_start), .hv_pump_enable(hv_pump_enable));

	// bus clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// catch launches and count pump-on cycles
	always @(posedge pclk) begin
		if (array_req_start === 1'b1) begin
			started <= 1'b1;
			req_seen <= array_req;
			dur <= 0;
		end else if (hv_pump_enable === 1'b1)
			dur <= dur + 1;
	end

	task automatic check(input string what, input logic [39:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one transfer: setup, access until pready, release, one idle edge
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16)
			mismatches++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// full command: array write, command code, launch
	task automatic go(input logic [15:0] a, input logic [7:0] d, c);
		started = 1'b0;
		apb(1'b1, ARR | a, {24'h0, d});
		apb(1'b1, {REG_PAGE, CMD_OFS}, {24'h0, c});
		apb(1'b1, ST, 32'h80);
		@(posedge pclk);
	endtask : go

	// status bits cbef, ccf and access error
	task automatic stat(input logic [7:0] exp);
		apb(1'b0, ST, 32'h0);
		check("status", rd & 32'hd0, exp);
	endtask : stat

	task automatic drain();
		span = 0;
		while (hv_pump_enable === 1'b1 && span < 400) begin
			@(posedge pclk);
			span++;
		end
	endtask : drain

	// wait for the end; per bus cycles make one timing tick
	task automatic fin(input int t);
		drain();
		check("pump span ok", dur >= t*per-3 && dur <= t*per+2, 1);
		stat(8'hc0);
	endtask : fin

	task automatic t_reset();
		stat(8'hc0);
		apb(1'b0, {REG_PAGE, OPT_OFS}, 32'h0);
		check("option copy", rd, 32'h00);
		apb(1'b0, {REG_PAGE, PROT_OFS}, 32'h0);
		check("protect copy", rd, 32'h5a);
		apb(1'b0, {REG_PAGE, DIV_OFS}, 32'h0);
		check("divider", rd, 32'h00);
		apb(1'b0, 32'h30, 32'h0);
		check("unmapped error", err, 1'b1);
		$display("test reset finished");
	endtask : t_reset

	// launch refused while no divider is set, then the error is cleared
	task automatic t_nodiv();
		go(16'h0500, 8'ha5, CMD_BYTE_PROG);
		check("started", started, 1'b0);
		stat(8'hd0);
		apb(1'b1, ST, 32'h10);
		stat(8'hc0);
		apb(1'b1, {REG_PAGE, DIV_OFS}, 32'h01);
		apb(1'b1, {REG_PAGE, DIV_OFS}, 32'h7f);
		apb(1'b0, {REG_PAGE, DIV_OFS}, 32'h0);
		check("divider once", rd, 32'h81);
		$display("test divider finished");
	endtask : t_nodiv

	task automatic t_prog();
		go(16'h0500, 8'ha5, CMD_BYTE_PROG);
		check("req", req_seen, {CMD_BYTE_PROG, 1'b0, 17'h00500, 8'ha5});
		fin(9);
		check("cell", mem_model.rd(0, 17'h00500), 8'ha5);
		check("pump", mem_model.pump_faults, 0);
		apb(1'b1, {REG_PAGE, CFG_OFS}, 32'h01);
		go(16'h0012, 8'h3c, CMD_BYTE_PROG);
		check("req", req_seen, {CMD_BYTE_PROG, 1'b1, 17'h00026, 8'h3c});
		fin(9);
		$display("test program finished");
	endtask : t_prog

	task automatic t_erase();
		go(16'h0503, 8'h77, CMD_SECTOR_ERASE);
		check("req", req_seen, {CMD_SECTOR_ERASE, 1'b0, 17'h00500, 8'h00});
		fin(30);
		check("cell", mem_model.rd(0, 17'h00500), 8'hff);
		check("other", mem_model.rd(1, 17'h00026), 8'h3c);
		apb(1'b1, {REG_PAGE, CFG_OFS}, 32'h00);
		go(16'h0011, 8'h00, CMD_SECTOR_ERASE);
		check("req", req_seen, {CMD_SECTOR_ERASE, 1'b1, 17'h00020, 8'h00});
		fin(30);
		check("back half", mem_model.rd(1, 17'h00026), 8'hff);
		go(16'h0777, 8'h12, CMD_MASS_ERASE);
		check("req", req_seen, {CMD_MASS_ERASE, 1'b0, 17'h00000, 8'h00});
		fin(60);
		go(16'h0100, 8'h99, CMD_BLANK_CHECK);
		check("req", req_seen, {CMD_BLANK_CHECK, 1'b1, 17'h00000, 8'h00});
		fin(9);
		$display("test erase finished");
	endtask : t_erase

	// broken sequences: bad code, manual abort, launch with error pending
	task automatic t_refuse();
		started = 1'b0;
		apb(1'b1, ARR | 32'h0500, 32'h55);
		apb(1'b1, {REG_PAGE, CMD_OFS}, 32'h33);
		check("started", started, 1'b0);
		stat(8'hd0);
		apb(1'b1, ST, 32'h10);
		apb(1'b1, ARR | 32'h0500, 32'h55);
		apb(1'b1, ST, 32'h00);
		stat(8'hd0);
		go(16'h0500, 8'h55, CMD_BYTE_PROG);
		check("started", started, 1'b0);
		apb(1'b1, ST, 32'h10);
		// a second array write before the command code is refused
		apb(1'b1, ARR | 32'h0500, 32'h55);
		apb(1'b1, ARR | 32'h0501, 32'h66);
		stat(8'hd0);
		apb(1'b1, ST, 32'h10);
		$display("test refuse finished");
	endtask : t_refuse

	task automatic t_burst();
		go(16'h0600, 8'h11, CMD_BURST_PROG);
		repeat (40) @(posedge pclk);
		check("pump held", hv_pump_enable, 1'b1);
		go(16'h0601, 8'h22, CMD_BURST_PROG);
		check("req", req_seen, {CMD_BURST_PROG, 1'b0, 17'h00601, 8'h22});
		repeat (40) @(posedge pclk);
		check("cell", mem_model.rd(0, 17'h00601), 8'h22);
		apb(1'b1, ARR | 32'h0602, 32'h33);
		apb(1'b1, ST, 32'h00);
		repeat (2) @(posedge pclk);
		check("pump off", hv_pump_enable, 1'b0);
		apb(1'b1, ST, 32'h10);
		go(16'h0700, 8'h00, CMD_SECTOR_ERASE);
		repeat (6) @(posedge pclk);
		go(16'h0700, 8'h00, CMD_ERASE_ABORT);
		drain();
		check("abort quick", span <= 12, 1'b1);
		stat(8'hc0);
		$display("test burst finished");
	endtask : t_burst

	// second reset with whole-sector eeprom pages
	task automatic t_mode1();
		presetn <= 1'b0;
		nv_option_in <= 8'h01;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, {REG_PAGE, OPT_OFS}, 32'h0);
		check("option copy", rd, 32'h01);
		// divider zero: one bus cycle per timing tick
		apb(1'b1, {REG_PAGE, DIV_OFS}, 32'h00);
		apb(1'b0, {REG_PAGE, DIV_OFS}, 32'h0);
		check("divider zero", rd, 32'h80);
		per = 1;
		apb(1'b1, {REG_PAGE, CFG_OFS}, 32'h01);
		go(16'h0012, 8'h5a, CMD_BYTE_PROG);
		check("req", req_seen, {CMD_BYTE_PROG, 1'b1, 17'h10012, 8'h5a});
		fin(9);
		check("reprogram", mem_model.reprog_faults, 0);
		$display("test sector mode finished");
	endtask : t_mode1

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		nv_option_in = 8'h00;
		nv_protect_in = 8'h5a;
		started = 1'b0;
		dur = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_nodiv();
		t_prog();
		t_erase();
		t_refuse();
		t_burst();
		t_mode1();
		results();
	end

	// watchdog against a hang
	initial begin
		repeat (30000) @(posedge pclk);
		mismatches++;
		results();
	end
endmodule : nvm_command_sequencer_bench
